// ===== core/spb_pkg.sv
// Constants and state types shared by the burst memory top and its burst counter.
// Assumes a single clock domain; no software-visible registers exist.
package spb_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Organisation
   localparam int ADDR_W_WIDE   = 20;   // 1M words
   localparam int ADDR_W_NARROW = 21;   // 2M words
   localparam int DATA_W_WIDE   = 36;
   localparam int DATA_W_NARROW = 18;
   localparam int LANE_W        = 9;    // One byte plus its parity bit

   ////////////////////////////////////////////////////////////////////////////////
   // Burst and timing
   localparam int       BURST_LEN   = 4;
   localparam int       CNT_W       = 2;
   localparam int       CLK_FREQ_HZ = 10_000_000;
   localparam int       WAKE_CYCLES = 2;     // Wake-up time, given in clock cycles
   localparam int       WAKE_W      = 2;
   localparam int       ENABLE_LAT  = 2;     // Cycles from select to driving data
   localparam int       DISABLE_LAT = 1;     // Not used by the top, which releases two cycles after deselect, as for select
   localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES);

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 2'h0;

   typedef struct packed {
      logic [CNT_W-1:0] start;   // Low address bits loaded at burst start
      logic [CNT_W-1:0] beats;   // Beats advanced since start, wraps at four
   } spb_ctr_state_t;

   localparam spb_ctr_state_t CTR_RST = '{start: CNT_RST, beats: CNT_RST};

endpackage : spb_pkg

// ===== core/spb_burst_if.sv
// Link between the memory top and its two-bit burst address counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface spb_burst_if;
   logic                      load;        // Start of burst, take load_bits
   logic [spb_pkg::CNT_W-1:0] load_bits;   // Two lowest address inputs
   logic                      advance;     // Step to next beat
   logic                      interleave;  // High selects interleaved order
   logic [spb_pkg::CNT_W-1:0] low_bits;    // Low address bits of current beat

   modport ctr  (input load, input load_bits, input advance, input interleave, output low_bits);
   modport user (output load, output load_bits, output advance, output interleave, input low_bits);
endinterface : spb_burst_if

// ===== core/spb_burst_ctr.sv
// Two-bit burst address counter with linear or interleaved beat order.
// Assumes the user gates load and advance while the memory is powered down.
`timescale 1ns/100ps
module spb_burst_ctr (
   input  wire logic i_mclk,
   input  wire logic i_nrst,
   spb_burst_if.ctr  bif
);

   spb_pkg::spb_ctr_state_t st_r;
   spb_pkg::spb_ctr_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      if (bif.load) begin
         st_nxt.start = bif.load_bits;
         st_nxt.beats = spb_pkg::CNT_RST;
      end else if (bif.advance) begin
         st_nxt.beats = st_r.beats + 2'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         st_r <= spb_pkg::CTR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Order is chosen live so a strap change takes effect without a clock.
   // Taken from the next state: an advance edge already addresses the stepped beat,
   // just as a start edge addresses the freshly loaded one
   assign bif.low_bits = bif.interleave ? (st_nxt.start ^ st_nxt.beats)
                                        : (st_nxt.start + st_nxt.beats);

endmodule : spb_burst_ctr

// ===== core/spb_sram_top.sv
// Synchronous pipelined burst static memory: array, control registers, read pipeline.
// Assumes the controlling logic shares i_mclk and meets setup on rising edges;
// the data pins are split into input, output and an active-low output enable.
`timescale 1ns/100ps
module spb_sram_top #(
   parameter bit WIDE_ORG = 1'b1,
   parameter int DATA_W   = WIDE_ORG ? spb_pkg::DATA_W_WIDE : spb_pkg::DATA_W_NARROW,
   parameter int ADDR_W   = WIDE_ORG ? spb_pkg::ADDR_W_WIDE : spb_pkg::ADDR_W_NARROW,
   parameter int LANES    = DATA_W / spb_pkg::LANE_W
) (
   input  wire logic              i_mclk,
   input  wire logic              i_nrst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic              i_proc_addr_strobe_n,
   input  wire logic              i_ctrl_addr_strobe_n,
   input  wire logic              i_burst_advance_n,
   input  wire logic              i_primary_select_n,
   input  wire logic              i_select_hi,
   input  wire logic              i_select_lo_n,
   input  wire logic              i_full_width_write_n,
   input  wire logic              i_byte_write_gate_n,
   input  wire logic [LANES-1:0]  i_lane_write_n,
   input  wire logic              i_output_enable_n,
   input  wire logic              i_burst_order_sel_n,
   input  wire logic              i_sleep_request,
   input  wire logic [DATA_W-1:0] i_data,
   output logic      [DATA_W-1:0] o_data,
   output logic                   o_data_oe_n,
   output logic                   o_power_down
);

   localparam int LW    = spb_pkg::LANE_W;
   localparam int DEPTH = 2 ** ADDR_W;

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter checks

   // Depth may be cut for simulation, never raised past the organisation
   if (ADDR_W < 3 || ADDR_W > (WIDE_ORG ? spb_pkg::ADDR_W_WIDE : spb_pkg::ADDR_W_NARROW)) begin : g_bad_addr
      $error("spb_sram_top: address width not supported by this organisation");
   end
   if (DATA_W != (WIDE_ORG ? spb_pkg::DATA_W_WIDE : spb_pkg::DATA_W_NARROW)) begin : g_bad_data
      $error("spb_sram_top: data width must match the organisation");
   end
   if (LANES * LW != DATA_W) begin : g_bad_lanes
      $error("spb_sram_top: lane count does not divide the data width");
   end
   if (spb_pkg::BURST_LEN != 2 ** spb_pkg::CNT_W) begin : g_bad_burst
      $error("spb_sram_top: burst length does not fit the counter");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic                      active;     // A burst is open
      logic [ADDR_W-1:0]         addr;       // Address captured at burst start
      logic                      rd1_vld;    // First read stage holds data
      logic [DATA_W-1:0]         rd1_data;
      logic                      rd2_vld;    // Output stage holds data
      logic [DATA_W-1:0]         rd2_data;
      logic                      sleep_s1;   // Sleep pin synchroniser
      logic                      sleep_s2;
      logic [spb_pkg::WAKE_W-1:0] wake_cnt;
      logic                      asleep;     // Powered down or still waking
   } spb_top_state_t;

   localparam spb_top_state_t TOP_RST = '{
      active:   1'b0,
      addr:     '0,
      rd1_vld:  1'b0,
      rd1_data: '0,
      rd2_vld:  1'b0,
      rd2_data: '0,
      sleep_s1: 1'b0,
      sleep_s2: 1'b0,
      wake_cnt: '0,
      asleep:   1'b0
   };

   spb_top_state_t st_r;
   spb_top_state_t st_nxt;

   spb_burst_if bif ();

   logic              chip_sel;
   logic              new_cmd;
   logic              run;
   logic              start;
   logic              stop;
   logic              proc_start;
   logic              cont;
   logic [LANES-1:0]  wr_lanes;
   logic              wr_en;
   logic              rd_en;
   logic [ADDR_W-1:0] acc_addr;
   logic [DATA_W-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Burst counter

   spb_burst_ctr u_ctr (
      .i_mclk (i_mclk),
      .i_nrst (i_nrst),
      .bif    (bif.ctr)
   );

   assign bif.load       = start;
   assign bif.load_bits  = i_addr[spb_pkg::CNT_W-1:0];
   // A counted strobe edge starts or ends the burst, so advance on that edge has no effect
   assign bif.advance    = cont & ~i_burst_advance_n;
   assign bif.interleave = i_burst_order_sel_n;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode

   always_comb begin
      chip_sel   = ~i_primary_select_n & i_select_hi & ~i_select_lo_n;
      // Processor strobe counts only while primary select is low
      new_cmd    = ~i_ctrl_addr_strobe_n | (~i_proc_addr_strobe_n & ~i_primary_select_n);
      run        = ~st_r.asleep;
      start      = run & new_cmd & chip_sel;
      stop       = run & new_cmd & ~chip_sel;
      proc_start = start & ~i_proc_addr_strobe_n & ~i_primary_select_n;
      cont       = run & st_r.active & ~new_cmd;
      acc_addr   = start ? i_addr : {st_r.addr[ADDR_W-1:spb_pkg::CNT_W], bif.low_bits};
   end

   // Lane selection; full-width write overrides gate and lanes
   always_comb begin
      if (!i_full_width_write_n) begin
         wr_lanes = '1;
      end else if (!i_byte_write_gate_n) begin
         wr_lanes = ~i_lane_write_n;
      end else begin
         wr_lanes = '0;
      end
   end

   // A processor-strobe start is always a read; its write data follows a cycle later
   always_comb begin
      wr_en = (|wr_lanes) & ((start & ~proc_start) | cont);
      rd_en = ~wr_en & (start | cont);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Array, one memory per lane so lane writes never collide

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [LW-1:0] lane_mem [DEPTH];

      // Write is taken on the edge; the array finishes it without further control
      always_ff @(posedge i_mclk) begin
         if (wr_en && wr_lanes[l]) begin
            lane_mem[acc_addr] <= i_data[l*LW +: LW];
         end
      end

      assign rd_word[l*LW +: LW] = lane_mem[acc_addr];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt = st_r;

      // Sleep pin is asynchronous to the clock, so it is synchronised first
      st_nxt.sleep_s1 = i_sleep_request;
      st_nxt.sleep_s2 = st_r.sleep_s1;
      if (st_r.sleep_s2) begin
         st_nxt.wake_cnt = spb_pkg::WAKE_LOAD;
      end else if (st_r.wake_cnt != '0) begin
         st_nxt.wake_cnt = st_r.wake_cnt - 2'h1;
      end
      st_nxt.asleep = st_r.sleep_s2 | (st_nxt.wake_cnt != '0);

      // While asleep every other field holds, preserving the burst in flight
      if (run) begin
         if (start) begin
            st_nxt.active = 1'b1;
            st_nxt.addr   = i_addr;
         end else if (stop) begin
            st_nxt.active = 1'b0;
         end

         st_nxt.rd1_vld = rd_en;
         if (rd_en) begin
            st_nxt.rd1_data = rd_word;
         end
         st_nxt.rd2_vld = st_r.rd1_vld;
         if (st_r.rd1_vld) begin
            st_nxt.rd2_data = st_r.rd1_data;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_nrst) begin
         st_r <= TOP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_data       = st_r.rd2_data;
   assign o_power_down = st_r.asleep;

   // Enable is combinational from the pins on purpose: the drivers must follow
   // output enable and sleep without a clock edge. Only this pin is not registered.
   assign o_data_oe_n = i_output_enable_n | ~st_r.rd2_vld | i_sleep_request;

endmodule : spb_sram_top

// ===== verif/spb_sram_sva.sv
// Port-level checks for the burst memory top, bound into every instance.
// Assumes one clock and the synchronous active-low reset of the top.
`timescale 1ns/100ps
module spb_sram_sva #(
   parameter int DATA_W = 36
) (
   input wire logic              i_mclk,
   input wire logic              i_nrst,
   input wire logic              i_proc_addr_strobe_n,
   input wire logic              i_ctrl_addr_strobe_n,
   input wire logic              i_primary_select_n,
   input wire logic              i_select_hi,
   input wire logic              i_select_lo_n,
   input wire logic              i_full_width_write_n,
   input wire logic              i_byte_write_gate_n,
   input wire logic              i_output_enable_n,
   input wire logic              i_sleep_request,
   input wire logic [DATA_W-1:0] o_data,
   input wire logic              o_data_oe_n,
   input wire logic              o_power_down
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   wire sel  = !i_primary_select_n && i_select_hi && !i_select_lo_n;
   wire idle = i_ctrl_addr_strobe_n && (i_proc_addr_strobe_n || i_primary_select_n) && !o_power_down;
   // Sleep excluded: it freezes the pipe and would hide the read
   wire rd   = !i_ctrl_addr_strobe_n && sel && i_full_width_write_n && i_byte_write_gate_n && !o_power_down
               && !i_sleep_request;
   AST_OE_ASYNC: assert property (i_output_enable_n |-> o_data_oe_n)
      else $error("driver on with output enable off");
   AST_SLEEP_OE: assert property (i_sleep_request |-> o_data_oe_n)
      else $error("driver on during sleep");
   AST_ENABLE: assert property (rd |-> ##2 o_data_oe_n == (i_output_enable_n || i_sleep_request))
      else $error("read not driven two cycles after start");
   AST_DISABLE: assert property (!i_ctrl_addr_strobe_n && !sel && !o_power_down ##1 idle |=> o_data_oe_n)
      else $error("driver still on after deselect");
   AST_PD_ENTER: assert property ($rose(i_sleep_request) |-> ##[1:4] o_power_down)
      else $error("power down not entered");
   AST_PD_HOLD: assert property ($past(o_power_down) |-> $stable(o_data))
      else $error("read data moved in power down");
   AST_WAKE: assert property ($fell(i_sleep_request) && o_power_down |-> o_power_down [*2])
      else $error("wake-up shorter than two cycles");
   AST_WAKE_END: assert property ($fell(i_sleep_request) ##1 !i_sleep_request [*7] |-> !o_power_down)
      else $error("power down did not end");
   cover property (rd);
   cover property ($rose(o_power_down));
   cover property (!i_ctrl_addr_strobe_n && !sel ##1 idle);
endmodule : spb_sram_sva

bind spb_sram_top spb_sram_sva #(.DATA_W(DATA_W)) u_sva (.i_mclk, .i_nrst, .i_proc_addr_strobe_n,
   .i_ctrl_addr_strobe_n, .i_primary_select_n, .i_select_hi, .i_select_lo_n, .i_full_width_write_n,
   .i_byte_write_gate_n, .i_output_enable_n, .i_sleep_request, .o_data, .o_data_oe_n, .o_power_down);

// ===== verif/spb_host_model.sv
// Controller model: drives controls, address, lane writes and write data of the memory.
// Assumes one clock shared with the memory; every change lands just after a rising edge.
`timescale 1ns/100ps
module spb_host_model (
   input  wire logic        i_mclk,
   output logic      [7:0]  o_ctl,
   output logic      [3:0]  o_addr,
   output logic      [3:0]  o_lane_n,
   output logic      [35:0] o_data
);
   initial {o_ctl, o_addr, o_lane_n, o_data} = {8'hd7, 4'h0, 4'hf, 36'h0};
   // Control bits: ctrl strobe, proc strobe, primary, sel hi, sel lo, advance, full write, gate
   task automatic drv(input logic [7:0] c, input logic [3:0] a, input logic [3:0] ln, input logic [35:0] d);
      @(posedge i_mclk);
      o_ctl    <= c;
      o_addr   <= a;
      o_lane_n <= ln;
      o_data   <= &c[1:0] ? ~o_data : d; // No write: bus must not keep showing the last word
   endtask : drv
endmodule : spb_host_model

// ===== verif/sync_pipelined_burst_sram_test.sv
// Self-checking bench for the burst memory top: writes, bursts, deselect, sleep.
// Assumes the controller model drives the clocked pins; static pins are driven here.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h, expected %h", $time, a, e); end end
module sync_pipelined_burst_sram_test;
   logic        mclk = 1'b0, nrst = 1'b0, oe_n = 1'b1, order_n = 1'b0, sleep = 1'b0;
   logic        data_oe_n, pwr_dn;
   logic [7:0]  ctl;
   logic [3:0]  addr, lane_n;
   logic [35:0] wdata, rdata;
   logic [35:0] mem [16];
   logic [5:0]  r;
   int          seed = 36697, err_total = 0, checked = 0, cyc = 0;

   spb_host_model i_host (.i_mclk(mclk), .o_ctl(ctl), .o_addr(addr), .o_lane_n(lane_n), .o_data(wdata));
   spb_sram_top #(.ADDR_W(4)) i_dut (.i_mclk(mclk), .i_nrst(nrst), .i_addr(addr),
      .i_proc_addr_strobe_n(ctl[6]), .i_ctrl_addr_strobe_n(ctl[7]), .i_burst_advance_n(ctl[2]),
      .i_primary_select_n(ctl[5]), .i_select_hi(ctl[4]), .i_select_lo_n(ctl[3]),
      .i_full_width_write_n(ctl[1]), .i_byte_write_gate_n(ctl[0]), .i_lane_write_n(lane_n),
      .i_output_enable_n(oe_n), .i_burst_order_sel_n(order_n), .i_sleep_request(sleep),
      .i_data(wdata), .o_data(rdata), .o_data_oe_n(data_oe_n), .o_power_down(pwr_dn));

   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin // About three times the length of the sequence
         err_total++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] beat_addr(input logic [3:0] a, input int b, input logic il);
      return {a[3:2], il ? a[1:0] ^ 2'(b) : a[1:0] + 2'(b)};
   endfunction : beat_addr

   task automatic wr(input logic [3:0] a, input logic full);
      logic [1:0]  fg;
      logic [3:0]  ln;
      logic [35:0] d;
      fg = full ? 2'b00 : 2'($random(seed));
      ln = 4'($random(seed));
      d = {4'($random(seed)), 32'($random(seed))};
      i_host.drv({6'h15, fg}, a, ln, d);
      for (int l = 0; l < 4; l++)
         if (!fg[1] || (!fg[0] && !ln[l])) mem[a][l*9 +: 9] = d[l*9 +: 9];
   endtask : wr

   // Deselect, start, three advances, a blocked proc strobe, then idle
   task automatic burst(input logic [3:0] a, input logic prc, input logic il);
      logic [7:0] c;
      for (int k = 0; k < 8; k++) begin
         c = k == 0 ? (a[0] ? 8'h5f : a[1] ? 8'h77 : 8'h47) : k == 1 ? (prc ? 8'h93 : 8'h53)
             : k < 5 ? 8'hd3 : k == 5 ? 8'hb7 : 8'hd7;
         i_host.drv(c, k == 5 ? ~a : a, 4'hf, 36'h0);
         if (k == 0) order_n <= il;
         oe_n <= 1'b0;
         #1;
         if (k == 2) `CHK(data_oe_n, 1'b1)
         if (k > 2) begin
            `CHK(data_oe_n, 1'b0)
            `CHK(rdata, mem[beat_addr(a, k > 6 ? 3 : k - 3, il)])
         end
      end
   endtask : burst

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   initial begin
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      for (int a = 0; a < 16; a++) wr(4'(a), 1'b1);
      repeat (40) wr(4'($random(seed)), 1'b0);
      #1 `CHK(data_oe_n, 1'b1)
      $display("test writes done");
      for (int n = 0; n < 24; n++) begin
         r = 6'($random(seed));
         if (n < 4) r[5:4] = 2'(n); // Each strobe and order pairing at least once
         burst(r[3:0], r[4], r[5]);
      end
      $display("test bursts done");
      i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      sleep <= 1'b1;
      repeat (5) i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      #1 `CHK({pwr_dn, data_oe_n}, 2'b11)
      i_host.drv(8'h54, 4'h5, 4'h0, ~mem[5]); // Must be dropped while asleep
      sleep <= 1'b0;
      i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      #1 `CHK(pwr_dn, 1'b1)
      repeat (7) i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      #1 `CHK(pwr_dn, 1'b0)
      burst(4'h4, 1'b0, 1'b0);
      $display("test sleep done");
      i_host.drv(8'h47, 4'h0, 4'hf, 36'h0);
      repeat (2) i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      #1 `CHK(data_oe_n, 1'b1)
      $display("test deselect done");
      // Mid-run reset: outputs return to idle, the array keeps its contents
      i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      nrst <= 1'b0;
      repeat (2) i_host.drv(8'hd7, 4'h0, 4'hf, 36'h0);
      nrst <= 1'b1;
      #1 `CHK({rdata, data_oe_n, pwr_dn}, {36'h0, 2'b10})
      // Processor start reads; the next write lands on beat 0, the advancing one on beat 1
      mem[4'h8] = {4'($random(seed)), 32'($random(seed))};
      mem[4'h9] = {4'($random(seed)), 32'($random(seed))};
      i_host.drv(8'h93, 4'h8, 4'hf, 36'h0);
      i_host.drv(8'hd4, 4'h0, 4'hf, mem[4'h8]);
      i_host.drv(8'hd0, 4'h0, 4'hf, mem[4'h9]);
      burst(4'h8, 1'b0, 1'b1);
      $display("test reset and write burst done");
      test_done();
   end
endmodule : sync_pipelined_burst_sram_test
